// [src/cdic_params.svh]
// Constants for the CMOS data input capture block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef CDIC_PARAMS_SVH
`define CDIC_PARAMS_SVH

// Register indices; byte address is four times the index
`define CDIC_IDX_POL      8'h20
`define CDIC_IDX_DIV      8'h22
`define CDIC_IDX_PHZ      8'h23
`define CDIC_IDX_LAT      8'h24
`define CDIC_IDX_FRAME    8'h25
`define CDIC_IDX_STATUS   8'h26
`define CDIC_IDX_WORD     8'h27
// Field positions
`define CDIC_POL_BIT      4
`define CDIC_DIV_HI       6
`define CDIC_DIV_LO       4
`define CDIC_PHZ_HI       7
`define CDIC_PHZ_LO       4
`define CDIC_LAT_HI       2
`define CDIC_LAT_LO       0
`define CDIC_AVL_HI       7
`define CDIC_AVL_LO       0
`define CDIC_NEED_HI      15
`define CDIC_NEED_LO      8
// Reset values
`define CDIC_DIV_RST      3'h1
`define CDIC_PHZ_RST      4'h0
`define CDIC_LAT_RST      3'h0
`define CDIC_AVL_RST      8'h10
`define CDIC_NEED_RST     8'h08
// Data clock period is this many divider steps
`define CDIC_PHASES       16
`define CDIC_HALF_PHASES  4'h8
`define CDIC_LAST_PHASE   4'hf
// Extra internal latency in the frame budget
`define CDIC_BUDGET_EXTRA 10'h002
// Register lanes
`define CDIC_DATA_W       32
`endif

// [src/cdic_pkg.sv]
// Types for the CMOS data input capture block.
// Assumes cdic_params.svh is reachable on the include path.
`include "cdic_params.svh"

package cdic_pkg;
	// Configuration held in the register file
	typedef struct packed {
		logic       clk_pol;
		logic [2:0] clk_div;
		logic [3:0] sample_phase;
		logic [2:0] rt_latency;
		logic [7:0] cyc_avail;
		logic [7:0] cyc_needed;
	} cdic_cfg_s;

	// One captured word with its frame position
	typedef struct packed {
		logic                    first;
		logic [`CDIC_DATA_W-1:0] data;
	} cdic_word_s;

	typedef logic [`CDIC_DATA_W-1:0] cdic_data_t;
endpackage : cdic_pkg

// [src/cdic_capture.sv]
// Capture logic for a CMOS parallel data input port with APB registers.
// Assumes one 100 MHz clock standing for the converter clock, and a data
// source that launches words from data_clock_out_o.
// Interface straps are sampled once, shortly after reset release.
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
`include "cdic_params.svh"

// Function
// - The device adds a 3-bit round-trip latency to its frame accounting.
// - Both interface straps high select CMOS mode with a data clock out.
// - The data clock runs at the converter clock over sixteen per step.
// - Bus data is captured on the rising edge of the sample clock.
// - The sample clock matches the data clock rate with a set phase.
// - Each phase step moves sampling by a sixteenth of the period.
module cdic_capture (
	input  wire logic             clock_i,       // Converter clock
	input  wire logic             nrst_i,        // Async reset, low
	input  wire logic             psel_i,        // APB select
	input  wire logic             penable_i,     // APB enable
	input  wire logic             pwrite_i,      // APB direction
	input  wire logic [11:0]      paddr_i,       // APB byte address
	input  wire logic [31:0]      pwdata_i,      // APB write data
	output logic      [31:0]      prdata_o,      // APB read data
	output logic                  pready_o,      // APB ready
	output logic                  pslverr_o,     // APB error
	input  wire logic             strap_ctrl_i,  // Interface strap A
	input  wire logic             strap_bus_i,   // Interface strap B
	input  wire cdic_pkg::cdic_data_t data_i,    // Data bus pins
	output logic                  data_clock_out_o,  // Data clock
	output logic                  frame_sync_out_o,  // Frame sync
	output cdic_pkg::cdic_word_s  word_o,        // Captured word
	output logic                  word_valid_o,  // Word strobe
	output logic                  budget_ok_o,   // Frame budget met
	output logic                  cmos_mode_o    // CMOS mode active
);
	import cdic_pkg::*;

	// Index match for one register; shared by every decode line below
	function automatic logic reg_hit(input logic [9:0] ix,
		input logic [7:0] reg_idx);
		return (ix == {2'h0, reg_idx});
	endfunction : reg_hit

	// Reset release through two flip-flops
	// Every other process resets on this copy, so all leave reset together
	logic rst_meta_r;
	logic rst_n_r;
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// Pin synchronisers; the first stage feeds only the second
	// A word is two clocks old when the capture register sees it; the
	// round-trip latency setting has to cover that delay as well
	cdic_data_t data_meta_r;
	cdic_data_t data_sync_r;
	logic [1:0] strap_meta_r;
	logic [1:0] strap_sync_r;
	always_ff @(posedge clock_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			data_meta_r  <= '0;
			data_sync_r  <= '0;
			strap_meta_r <= 2'h0;
			strap_sync_r <= 2'h0;
		end else begin
			data_meta_r  <= data_i;
			data_sync_r  <= data_meta_r;
			strap_meta_r <= {strap_ctrl_i, strap_bus_i};
			strap_sync_r <= strap_meta_r;
		end
	end

	// Straps are caught once after reset release, as on a real part.
	// The synchroniser needs two edges before its output shows the pins,
	// so the latch stays open for three edges and keeps the last look.
	logic       strap_done_r;
	logic       cmos_r;
	logic [1:0] strap_cnt_r;
	always_ff @(posedge clock_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			strap_cnt_r  <= 2'h0;
			strap_done_r <= 1'b0;
			cmos_r       <= 1'b0;
		end else if (!strap_done_r) begin
			strap_cnt_r  <= strap_cnt_r + 2'h1;
			strap_done_r <= (strap_cnt_r == 2'h2);
			cmos_r       <= &strap_sync_r;
		end
	end
	// Mode output follows the latched straps until the next reset
	assign cmos_mode_o = cmos_r;

	// APB decode; slave answers without wait states
	// Writes need no setup-phase state: the access edge commits them, and
	// a read is a pure multiplexer on the held address
	cdic_cfg_s  cfg_r;
	logic [9:0] idx;
	logic       acc;
	logic       wr;
	logic       hit_pol;
	logic       hit_div;
	logic       hit_phz;
	logic       hit_lat;
	logic       hit_frm;
	logic       hit_sts;
	logic       hit_wrd;
	logic       mapped;
	assign idx     = paddr_i[11:2];
	assign acc     = psel_i & penable_i;
	assign wr      = acc & pwrite_i;
	assign hit_pol = reg_hit(idx, `CDIC_IDX_POL);
	assign hit_div = reg_hit(idx, `CDIC_IDX_DIV);
	assign hit_phz = reg_hit(idx, `CDIC_IDX_PHZ);
	assign hit_lat = reg_hit(idx, `CDIC_IDX_LAT);
	assign hit_frm = reg_hit(idx, `CDIC_IDX_FRAME);
	assign hit_sts = reg_hit(idx, `CDIC_IDX_STATUS);
	assign hit_wrd = reg_hit(idx, `CDIC_IDX_WORD);
	assign mapped  = hit_pol | hit_div | hit_phz | hit_lat | hit_frm |
		hit_sts | hit_wrd;
	// Zero wait states: every access completes in its first enable cycle
	assign pready_o  = 1'b1;
	assign pslverr_o = acc & ~mapped;

	// Configuration writes take effect at the access edge
	// Unmapped writes fall through every decode and change nothing
	always_ff @(posedge clock_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			cfg_r.clk_pol      <= 1'b0;
			cfg_r.clk_div      <= `CDIC_DIV_RST;
			cfg_r.sample_phase <= `CDIC_PHZ_RST;
			cfg_r.rt_latency   <= `CDIC_LAT_RST;
			cfg_r.cyc_avail    <= `CDIC_AVL_RST;
			cfg_r.cyc_needed   <= `CDIC_NEED_RST;
		end else if (wr) begin
			if (hit_pol)
				cfg_r.clk_pol <= pwdata_i[`CDIC_POL_BIT];
			if (hit_div)
				cfg_r.clk_div <= pwdata_i[`CDIC_DIV_HI:`CDIC_DIV_LO];
			if (hit_phz)
				cfg_r.sample_phase <= pwdata_i[`CDIC_PHZ_HI:`CDIC_PHZ_LO];
			if (hit_lat)
				cfg_r.rt_latency <= pwdata_i[`CDIC_LAT_HI:`CDIC_LAT_LO];
			if (hit_frm) begin
				cfg_r.cyc_avail  <= pwdata_i[`CDIC_AVL_HI:`CDIC_AVL_LO];
				cfg_r.cyc_needed <= pwdata_i[`CDIC_NEED_HI:`CDIC_NEED_LO];
			end
		end
	end

	// Frame budget: available cycles against need, latency and internals
	// Ten bits hold the largest sum, so the compare never sees a wrap
	logic [9:0] budget_need;
	assign budget_need = {2'h0, cfg_r.cyc_needed} +
		{7'h00, cfg_r.rt_latency} + `CDIC_BUDGET_EXTRA;
	assign budget_ok_o = ({2'h0, cfg_r.cyc_avail} >= budget_need);

	// Divider step: a zero setting behaves as one to keep a clock alive
	logic [2:0] div_eff;
	logic [2:0] pre_r;
	logic [3:0] ph_r;
	logic       step;
	logic       period_start;
	logic       sample_now;
	assign div_eff = (cfg_r.clk_div == 3'h0) ? 3'h1 : cfg_r.clk_div;
	// A setting lowered mid-step ends the step at once; waiting for the
	// prescaler to wrap would repeat a sample instant within one phase
	assign step    = (pre_r >= div_eff - 3'h1);
	// One period is sixteen steps, each of div_eff converter clocks
	assign period_start = cmos_r & (pre_r == 3'h0) & (ph_r == 4'h0);
	// Sample clock rises in the step chosen by the phase field
	assign sample_now = cmos_r & (pre_r == 3'h0) &
		(ph_r == cfg_r.sample_phase);

	// Prescaler and phase step; both park at zero outside CMOS mode so
	// the first period after start-up begins cleanly at phase zero
	always_ff @(posedge clock_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pre_r <= 3'h0;
			ph_r  <= 4'h0;
		end else if (!cmos_r) begin
			pre_r <= 3'h0;
			ph_r  <= 4'h0;
		end else if (step) begin
			pre_r <= 3'h0;
			ph_r  <= ph_r + 4'h1;
		end else begin
			pre_r <= pre_r + 3'h1;
		end
	end

	// Data clock: high for the first half of each period, polarity set
	// Registered so the pin never glitches when the phase count rolls
	logic dclk_r;
	always_ff @(posedge clock_i or negedge rst_n_r) begin
		if (!rst_n_r)
			dclk_r <= 1'b0;
		else
			dclk_r <= cmos_r & ((ph_r < `CDIC_HALF_PHASES) ^ cfg_r.clk_pol);
	end
	assign data_clock_out_o = dclk_r;

	// Frame counter in data clock periods; sync lasts one period
	// A frame length of zero or one gives a sync pulse every period
	logic [7:0] frm_cnt_r;
	logic [7:0] frm_cnt_nxt;
	logic       frame_start;
	logic       fs_r;
	assign frm_cnt_nxt = (frm_cnt_r + 8'h01 >= cfg_r.cyc_avail) ? 8'h00 :
		frm_cnt_r + 8'h01;
	// Sync rises with the first period of each new frame
	assign frame_start = period_start & (frm_cnt_nxt == 8'h00);
	always_ff @(posedge clock_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			frm_cnt_r <= 8'h00;
			fs_r      <= 1'b0;
		end else if (!cmos_r) begin
			frm_cnt_r <= 8'h00;
			fs_r      <= 1'b0;
		end else if (period_start) begin
			frm_cnt_r <= frm_cnt_nxt;
			fs_r      <= frame_start;
		end
	end
	assign frame_sync_out_o = fs_r;

	// Sample count since the frame pulse; words arrive after the latency
	// Samples taken in the frame-start period count as index zero, so the
	// first word kept is the one at index one above the latency setting
	logic [7:0] samp_r;
	logic [7:0] samp_base;
	logic [7:0] first_idx;
	logic [7:0] last_idx;
	logic       in_window;
	assign samp_base = frame_start ? 8'h00 : samp_r;
	assign first_idx = {5'h00, cfg_r.rt_latency} + 8'h01;
	assign last_idx  = first_idx + cfg_r.cyc_needed;
	assign in_window = (samp_base >= first_idx) & (samp_base < last_idx);
	// The count saturates so a very long frame cannot wrap into the window
	always_ff @(posedge clock_i or negedge rst_n_r) begin
		if (!rst_n_r)
			samp_r <= 8'h00;
		else if (sample_now && samp_base != 8'hff)
			samp_r <= samp_base + 8'h01;
		else
			samp_r <= samp_base;
	end

	// Capture register loads at the sample clock rising instant
	// The word holds until the next capture, so software may read it late
	cdic_word_s word_r;
	logic       wvalid_r;
	always_ff @(posedge clock_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			word_r   <= '0;
			wvalid_r <= 1'b0;
		end else begin
			wvalid_r <= sample_now & in_window;
			if (sample_now & in_window) begin
				word_r.data  <= data_sync_r;
				word_r.first <= (samp_base == first_idx);
			end
		end
	end
	// Outputs come straight from the capture flops
	assign word_o       = word_r;
	assign word_valid_o = wvalid_r;

	// Read multiplexer; unmapped reads return zero
	// Status and word reads replace the whole lane rather than merge fields
	// Status packs the frame count, sync, mode and budget flags
	logic [31:0] rd_status;
	assign rd_status = {24'h000000, frm_cnt_r[3:0], 1'b0, fs_r,
		cmos_r, budget_ok_o};
	always_comb begin
		prdata_o = 32'h00000000;
		if (hit_pol)
			prdata_o[`CDIC_POL_BIT] = cfg_r.clk_pol;
		if (hit_div)
			prdata_o[`CDIC_DIV_HI:`CDIC_DIV_LO] = cfg_r.clk_div;
		if (hit_phz)
			prdata_o[`CDIC_PHZ_HI:`CDIC_PHZ_LO] = cfg_r.sample_phase;
		if (hit_lat)
			prdata_o[`CDIC_LAT_HI:`CDIC_LAT_LO] = cfg_r.rt_latency;
		if (hit_frm) begin
			prdata_o[`CDIC_AVL_HI:`CDIC_AVL_LO]   = cfg_r.cyc_avail;
			prdata_o[`CDIC_NEED_HI:`CDIC_NEED_LO] = cfg_r.cyc_needed;
		end
		if (hit_sts)
			prdata_o = rd_status;
		if (hit_wrd)
			prdata_o = word_r.data;
	end
endmodule : cdic_capture

// [sim/cdic_capture_assertions.sv]
// Port checker for cdic_capture, attached by bind.
// Assumes config writes land at the APB access edge.
`timescale 1ns/1ps
module cdic_chk (
	input wire logic                 clock_i,          // Clock
	input wire logic                 nrst_i,           // Reset
	input wire logic                 psel_i,           // Select
	input wire logic                 penable_i,        // Enable
	input wire logic                 pwrite_i,         // Write
	input wire logic [11:0]          paddr_i,          // Address
	input wire logic [31:0]          pwdata_i,         // Wdata
	input wire logic [31:0]          prdata_o,         // Rdata
	input wire logic                 pready_o,         // Ready
	input wire logic                 pslverr_o,        // Error
	input wire logic                 data_clock_out_o, // Clock out
	input wire cdic_pkg::cdic_word_s word_o,           // Word
	input wire logic                 word_valid_o,     // Strobe
	input wire logic                 budget_ok_o,      // Budget
	input wire logic                 cmos_mode_o       // Mode
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	// Decode of the access and the mapped indices
	wire [9:0] idx = paddr_i[11:2];
	wire       acc = psel_i & penable_i;
	wire       map = (idx == 10'h20) || (idx >= 10'h22 && idx <= 10'h27);
	logic [2:0] lat_r;
	logic [7:0] avl_r;
	logic [7:0] nd_r;
	// Shadow of the budget fields, so budget can be judged from ports
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lat_r <= 3'h0;
			avl_r <= 8'h10;
			nd_r  <= 8'h08;
		end else if (acc & pwrite_i & pready_o) begin
			if (idx == 10'h24) lat_r <= pwdata_i[2:0];
			if (idx == 10'h25) {nd_r, avl_r} <= pwdata_i[15:0];
		end
	end
	// Clocks since the last strobe and since the last phase write; both
	// saturate, since only short distances matter
	logic [7:0] gap_r;
	logic [7:0] quiet_r;
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			gap_r   <= 8'hff;
			quiet_r <= 8'hff;
		end else begin
			if (word_valid_o)
				gap_r <= 8'h01;
			else if (gap_r != 8'hff)
				gap_r <= gap_r + 8'h01;
			if (acc & pwrite_i & (idx == 10'h23))
				quiet_r <= 8'h01;
			else if (quiet_r != 8'hff)
				quiet_r <= quiet_r + 8'h01;
		end
	end
	a_ready_high: assert property (pready_o) else $error("pready low");
	a_err_unmapped: assert property (acc |-> pslverr_o == !map)
		else $error("pslverr wrong");
	a_read_zero: assert property (acc & !pwrite_i & !map |-> !prdata_o)
		else $error("unmapped read not zero");
	a_budget_match: assert property (budget_ok_o ==
		({2'h0, avl_r} >= {2'h0, nd_r} + lat_r + 10'h2))
		else $error("budget flag wrong");
	a_strobe_spacing: assert property (word_valid_o &&
		(quiet_r == 8'hff || quiet_r >= gap_r + 8'h02) |-> gap_r >= 8'h10)
		else $error("words too close");
	a_mode_gate: assert property (!cmos_mode_o |-> !word_valid_o)
		else $error("capture outside mode");
	a_word_hold: assert property (!word_valid_o |-> $stable(word_o))
		else $error("word moved without strobe");
	a_clock_high: assert property ($rose(data_clock_out_o) |=>
		data_clock_out_o[*7]) else $error("clock high too short");
endmodule : cdic_chk
bind cdic_capture cdic_chk cdic_chk_inst (.clock_i, .nrst_i, .psel_i,
	.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
	.pslverr_o, .data_clock_out_o, .word_o, .word_valid_o, .budget_ok_o,
	.cmos_mode_o);

// [sim/cdic_src.sv]
// Data source model driving the capture block's data pins.
// Assumes it may watch the data clock on the converter clock.
`timescale 1ns/1ps
module cdic_src (
	input  wire logic            clock_i, // Clock
	input  wire logic            dco_i,   // Data clock
	input  wire logic            fs_i,    // Frame sync
	output cdic_pkg::cdic_data_t data_o   // Data pins
);
	import cdic_pkg::*;
	logic       dprev_r = 1'h0;
	logic [7:0] idx_r = 8'h0;
	initial data_o = 32'h0;
	// New word at each data clock rise, counted from frame sync
	always @(posedge clock_i) begin
		dprev_r <= dco_i;
		if (dco_i && !dprev_r) begin
			idx_r  <= fs_i ? 8'h0 : idx_r + 8'h1;
			data_o <= {8'hc3, 16'h0, idx_r};
		end
	end
endmodule : cdic_src

// [sim/tb_top.sv]
// Self-checking bench for cdic_capture with a data source model.
// Assumes both straps high select CMOS mode at start-up.
`timescale 1ns/1ps
module tb_top;
	import cdic_pkg::*;
	typedef struct packed {
		logic        w;
		logic [7:0]  i;
		logic [31:0] d;
		logic        e;
	} cdic_row_s;
	logic clock_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic strap_ctrl_i, strap_bus_i, data_clock_out_o, frame_sync_out_o;
	logic word_valid_o, budget_ok_o, cmos_mode_o, dprev, f, er, fprev;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	cdic_data_t  data_i;
	cdic_word_s  word_o;
	int bad_count = 0;
	int samples_checked = 0;
	int cnt = 0;
	int per = 0;
	int fcnt = 0;
	int fper = 0;
	int n, off, o0;
	// Write, read back, unmapped access
	cdic_row_s rows [13] = '{'{1'h0, 8'h22, 32'h10, 1'h0},
		'{1'h0, 8'h25, 32'h810, 1'h0}, '{1'h0, 8'h24, 32'h0, 1'h0},
		'{1'h1, 8'h21, 32'hff, 1'h1}, '{1'h0, 8'h21, 32'h0, 1'h1},
		'{1'h1, 8'h23, 32'hf0, 1'h0}, '{1'h0, 8'h23, 32'hf0, 1'h0},
		'{1'h1, 8'h24, 32'h3, 1'h0}, '{1'h0, 8'h24, 32'h3, 1'h0},
		'{1'h1, 8'h25, 32'h408, 1'h0}, '{1'h0, 8'h25, 32'h408, 1'h0},
		'{1'h1, 8'h22, 32'h20, 1'h0}, '{1'h0, 8'h22, 32'h20, 1'h0}};
	cdic_capture cdic_capture_inst (.clock_i, .nrst_i, .psel_i, .penable_i,
		.pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
		.strap_ctrl_i, .strap_bus_i, .data_i, .data_clock_out_o,
		.frame_sync_out_o, .word_o, .word_valid_o, .budget_ok_o, .cmos_mode_o);
	cdic_src cdic_src_inst (.clock_i, .dco_i(data_clock_out_o),
		.fs_i(frame_sync_out_o), .data_o(data_i));
	initial begin
		clock_i = 1'h0;
		forever #5 clock_i = ~clock_i;
	end
	// Clocks since the last data clock rise, and the last period;
	// the same for frame sync rises
	always @(posedge clock_i) begin
		dprev <= data_clock_out_o;
		fprev <= frame_sync_out_o;
		if (frame_sync_out_o && !fprev) begin
			fper <= fcnt;
			fcnt <= 1;
		end else begin
			fcnt <= fcnt + 1;
		end
		if (data_clock_out_o && !dprev) begin
			per <= cnt;
			cnt <= 1;
		end else begin
			cnt <= cnt + 1;
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic print_verdict();
		$display("checks %0d errors %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	// One APB transfer, then an idle cycle
	task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
		int k;
		psel_i <= 1'h1;
		pwrite_i <= w;
		paddr_i <= {2'h0, i, 2'h0};
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'h1;
		for (k = 0; k < 20; k++) begin
			@(posedge clock_i);
			if (pready_o === 1'h1) break;
		end
		if (pready_o !== 1'h1) begin
			bad_count++;
			print_verdict();
		end
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'h0;
		penable_i <= 1'h0;
		@(posedge clock_i);
	endtask : apb
	// Next word strobe, with its offset into the data clock period
	task automatic wv();
		int k;
		for (k = 0; k < 3000; k++) begin
			@(posedge clock_i);
			if (word_valid_o === 1'h1) begin
				f = word_o.first;
				off = cnt;
				return;
			end
		end
		bad_count++;
		print_verdict();
	endtask : wv
	initial begin
		{nrst_i, psel_i, penable_i, pwrite_i} = 4'h0;
		{paddr_i, pwdata_i} = 44'h0;
		{strap_ctrl_i, strap_bus_i} = 2'h3;
		repeat (8) @(posedge clock_i);
		nrst_i <= 1'h1;
		repeat (8) @(posedge clock_i);
		chk("budget", 32'h1, budget_ok_o);
		chk("mode", 32'h1, cmos_mode_o);
		foreach (rows[j]) begin
			apb(rows[j].w, rows[j].i, rows[j].d);
			if (!rows[j].w) chk("rdata", rows[j].d, rd);
			chk("slverr", rows[j].e, er);
		end
		chk("budget", 32'h0, budget_ok_o);
		apb(1'h1, 8'h24, 32'h2);
		apb(1'h1, 8'h23, 32'h0);
		apb(1'h0, 8'h26, 32'h0);
		chk("status", 32'h1, rd[0]);
		repeat (100) @(posedge clock_i);
		chk("period", 32'h20, per);
		for (n = 0; n < 20; n++) begin wv(); if (f) break; end
		for (n = 1; n < 20; n++) begin wv(); if (f) break; end
		chk("words", 32'h4, n);
		chk("frame", 32'h100, fper);
		chk("tag", 32'hc3, word_o.data[31:24]);
		o0 = off;
		apb(1'h1, 8'h23, 32'h40);
		wv();
		wv();
		chk("phase", 32'h8, (off - o0 + per) % per);
		apb(1'h0, 8'h27, 32'h0);
		chk("wordreg", 32'hc3, rd[31:24]);
		strap_bus_i <= 1'h0;
		nrst_i <= 1'h0;
		repeat (8) @(posedge clock_i);
		nrst_i <= 1'h1;
		repeat (8) @(posedge clock_i);
		chk("mode", 32'h0, cmos_mode_o);
		n = 0;
		repeat (400) begin
			@(posedge clock_i);
			if (word_valid_o !== 1'h0) n++;
		end
		chk("words", 32'h0, n);
		print_verdict();
	end
endmodule : tb_top
